// ### rtl/pgr_map.svh
// Register map, field positions and timing counts of the pin unit.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
//
// What this block does
// - Pins work in power-down and active modes; inputs may be switched off in power-down.
// - Other modes: all pins high-impedance open-drain, no input detection, config retained.
// - Two-bit function: 0 alternate, 1 input, 2 open-drain, 3 push-pull.
// - Input polarity bit 0 means active low, 1 active high.
// - Input level bit 1 enables debounce filter, 0 bypasses it.
// - Active edge of a general input raises an event.
// - Event becomes wakeup only when enabled; sense bit picks edge or level.
// - Pull enable connects internal pull-down on a general input.
// - Only inputs 1 to 3 steer regulators, using polarity-adjusted level.
// - Selected input sets regulator on bit when active, clears it when passive.
// - Selected input sets voltage selection when active, clears it when passive.
// - One input may drive many regulators; sequencer ignored, software writes still work.
// - Pin 3 active edge feeds the sequencer hold input.
// - Output with source 0 drives the level bit.
// - Nonzero source drives forwarding, sequencer or supply fault.
// - Open-drain output uses pull enable for an internal pull-up.
// - Supply fault asserts after supply low over 100 ms; level bit inverts it.
// - Alternate inputs 0 and 2 have no events, alternate input 4 sets its event; optional debounce.
// - Platform-on pin edge sets bit; assert wakes with event, deassert starts power-down.
// - Run-request pin edge sets bit; assertion wakes only when enabled.
// - Watchdog service rising edge resets counter; held asserted stops counting.
// - Debounced inputs 0 to 3 can be forwarded to outputs 0, 1, 3.
`ifndef PGR_MAP_SVH
`define PGR_MAP_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PGR_OFS_PIN0 8'h00
`define PGR_OFS_PIN4 8'h10
`define PGR_OFS_CTRL 8'h14
`define PGR_OFS_ONSRC 8'h18
`define PGR_OFS_VSRC 8'h1C
`define PGR_OFS_ONBIT 8'h20
`define PGR_OFS_VSEL 8'h24
`define PGR_OFS_STAT 8'h28
`define PGR_OFS_EVT 8'h2C
// ----------------------------------------------------------------------
// Fields, reset values and timing
// ----------------------------------------------------------------------
`define PGR_CFG_W 11
`define PGR_CTRL_INOFF 0
`define PGR_CTRL_ALTDEB 1
`define PGR_CTRL_DEB_LSB 16
`define PGR_DEB_RST 16'h0010
`define PGR_CLK_NS 5
`define PGR_FAULT_MS 100
`define PGR_FAULT_CYC (`PGR_FAULT_MS * 1000000 / `PGR_CLK_NS)
`endif

// ### rtl/pgr_pkg.sv
// Types shared by the pin unit and whoever instantiates it.
// Assumes nothing beyond a SystemVerilog compiler.
package pgr_pkg;
  typedef enum logic [1:0] {
    PGR_ALT = 2'h0,
    PGR_GPI = 2'h1,
    PGR_OD = 2'h2,
    PGR_PP = 2'h3
  } pgr_func_t;

  typedef struct packed {
    logic [1:0] fwd;
    logic [1:0] src;
    logic pull;
    logic wen;
    logic wsense;
    logic pol;
    logic level;
    pgr_func_t func;
  } pgr_pin_cfg_t;

  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe_n;
    logic [4:0] pull_up;
    logic [4:0] pull_dn;
  } pgr_pads_t;
endpackage

// ### rtl/pgr_gpio.sv
// Five-pin I/O unit with regulator control, reached over APB.
// Assumes pads are resolved outside from out, oe_n and the pull requests.
`timescale 1ns/1ps
`default_nettype none
`include "pgr_map.svh"
module pgr_gpio #(
  parameter int NREG = 4,
  parameter int FAULT_CYCLES = `PGR_FAULT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] pad_in,
  output pgr_pkg::pgr_pads_t pads,
  input wire logic mode_active,
  input wire logic mode_powerdown,
  input wire logic vsys_low,
  input wire logic [4:0] seq_pin,
  input wire logic [NREG-1:0] seq_on_we,
  input wire logic [NREG-1:0] seq_on_val,
  input wire logic [NREG-1:0] seq_vsel_we,
  input wire logic [NREG-1:0] seq_vsel_val,
  output logic [NREG-1:0] reg_on,
  output logic [NREG-1:0] reg_vsel,
  output logic seq_wait_edge,
  output logic wakeup,
  output logic platform_on,
  output logic run_request,
  output logic powerdown_req,
  output logic wd_service,
  output logic wd_hold,
  output logic supply_fault
);
  import pgr_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  pgr_pin_cfg_t cfg_r [5];
  logic in_off_r, alt_deb_r;
  logic [15:0] deb_len_r;
  logic [31:0] on_src_r, v_src_r;
  logic [4:0] evt_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [31:0] rd_nxt;
  logic addr_ok;

  // Picks the edge of input 1..3 named by a two-bit source code.
  function automatic logic src_hit(input logic [1:0] code,
                                   input logic [4:0] v);
    src_hit = (code != 2'h0) && v[code];
  endfunction

  wire logic setup = psel && !penable;
  wire logic wr = psel && penable && pwrite;
  wire logic [2:0] pidx = paddr[4:2];

  // ----------------------------------------------------------------------
  // Pin input path
  // ----------------------------------------------------------------------
  logic [4:0] s1_r, s2_r, s3_r, in_r, filt_r, prev_r;
  logic [15:0] cnt_r [5];
  logic [4:0] act, rise, fall, gpi, alt, deb_en;
  wire logic run_ok = mode_active || mode_powerdown;
  // Inputs may be shut off in power-down to save the pad current.
  wire logic in_ok = run_ok && !(mode_powerdown && in_off_r);

  // Three-stage synchroniser; a level counts once stages two and three
  // agree, so a glitch caught by the first stage is never seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
      in_r <= 5'h00;
    end else begin
      s1_r <= pad_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 5; i++) begin
        if (s2_r[i] == s3_r[i]) in_r[i] <= s3_r[i];
      end
    end
  end

  // Per-pin decode of function, polarity and edges.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      gpi[i] = cfg_r[i].func == PGR_GPI;
      alt[i] = cfg_r[i].func == PGR_ALT;
      // Alternate inputs only use the filter when software asks for it.
      deb_en[i] = gpi[i] ? cfg_r[i].level : (alt[i] && alt_deb_r);
      act[i] = filt_r[i] ^ ~cfg_r[i].pol;
    end
    rise = act & ~prev_r & {5{in_ok}};
    fall = ~act & prev_r & {5{in_ok}};
  end

  // Debounce: the filtered level follows only after the new level has
  // held for deb_len_r cycles; while inputs are off it stays frozen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_r <= 5'h00;
      for (int i = 0; i < 5; i++) cnt_r[i] <= 16'h0000;
    end else if (in_ok) begin
      for (int i = 0; i < 5; i++) begin
        if (!deb_en[i] || in_r[i] == filt_r[i]) begin
          filt_r[i] <= in_r[i];
          cnt_r[i] <= 16'h0000;
        end else if (cnt_r[i] + 16'h0001 >= deb_len_r) begin
          filt_r[i] <= in_r[i];
          cnt_r[i] <= 16'h0000;
        end else begin
          cnt_r[i] <= cnt_r[i] + 16'h0001;
        end
      end
    end
  end

  // Edge history tracks act while inputs are off, but the filter is frozen, so
  // re-enabling fires an edge for a change it missed. Reset
  // configuration reads every pin as active, so history starts there.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 5'h1F;
    end else begin
      prev_r <= act;
    end
  end

  // ----------------------------------------------------------------------
  // Events, wakeup and alternate functions
  // ----------------------------------------------------------------------
  logic wake_nxt;
  logic [4:0] evt_set;
  always_comb begin
    evt_set = gpi & rise;
    evt_set[4] = evt_set[4] || (alt[4] && rise[4]);
    wake_nxt = (alt[4] && rise[4])
      || (alt[2] && rise[2] && cfg_r[2].wen);
    for (int i = 0; i < 5; i++) begin
      if (gpi[i] && cfg_r[i].wen) begin
        wake_nxt = wake_nxt || (cfg_r[i].wsense ? act[i] && in_ok
                                                : rise[i]);
      end
    end
  end

  // Alternate pins drive their bits through edges, except wd_hold, which follows the level of pin 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup <= 1'b0;
      platform_on <= 1'b0;
      run_request <= 1'b0;
      powerdown_req <= 1'b0;
      wd_service <= 1'b0;
      wd_hold <= 1'b0;
      seq_wait_edge <= 1'b0;
    end else begin
      wakeup <= wake_nxt;
      if (alt[4] && rise[4]) platform_on <= 1'b1;
      else if (alt[4] && fall[4]) platform_on <= 1'b0;
      if (alt[2] && rise[2]) run_request <= 1'b1;
      else if (alt[2] && fall[2]) run_request <= 1'b0;
      powerdown_req <= alt[4] && fall[4];
      wd_service <= alt[0] && rise[0];
      wd_hold <= alt[0] && act[0] && in_ok;
      seq_wait_edge <= gpi[3] && rise[3];
    end
  end

  // ----------------------------------------------------------------------
  // Regulator control from inputs 1 to 3
  // ----------------------------------------------------------------------
  wire logic [4:0] g_rise = rise & gpi & 5'h0E;
  wire logic [4:0] g_fall = fall & gpi & 5'h0E;

  // Pin edges win over a same-cycle register write; the sequencer only
  // reaches functions that no pin owns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_on <= '0;
      reg_vsel <= '0;
    end else begin
      for (int j = 0; j < NREG; j++) begin
        if (src_hit(on_src_r[2*j+:2], g_rise)) reg_on[j] <= 1'b1;
        else if (src_hit(on_src_r[2*j+:2], g_fall)) reg_on[j] <= 1'b0;
        else if (wr && paddr == `PGR_OFS_ONBIT) reg_on[j] <= pwdata[j];
        else if (on_src_r[2*j+:2] == 2'h0 && seq_on_we[j]) begin
          reg_on[j] <= seq_on_val[j];
        end
        if (src_hit(v_src_r[2*j+:2], g_rise)) reg_vsel[j] <= 1'b1;
        else if (src_hit(v_src_r[2*j+:2], g_fall)) reg_vsel[j] <= 1'b0;
        else if (wr && paddr == `PGR_OFS_VSEL) reg_vsel[j] <= pwdata[j];
        else if (v_src_r[2*j+:2] == 2'h0 && seq_vsel_we[j]) begin
          reg_vsel[j] <= seq_vsel_val[j];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Supply fault and output drivers
  // ----------------------------------------------------------------------
  logic v1_r, v2_r, v3_r, vlow_r;
  logic [31:0] fcnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v1_r <= 1'b0;
      v2_r <= 1'b0;
      v3_r <= 1'b0;
      vlow_r <= 1'b0;
      fcnt_r <= 32'h0000_0000;
      supply_fault <= 1'b0;
    end else begin
      v1_r <= vsys_low;
      v2_r <= v1_r;
      v3_r <= v2_r;
      if (v2_r == v3_r) vlow_r <= v3_r;
      if (!vlow_r) begin
        fcnt_r <= 32'h0000_0000;
        supply_fault <= 1'b0;
      end else if (fcnt_r < 32'(FAULT_CYCLES)) begin
        fcnt_r <= fcnt_r + 32'h0000_0001;
      end else begin
        supply_fault <= 1'b1;
      end
    end
  end

  logic [4:0] oval;
  pgr_pads_t pads_nxt;
  always_comb begin
    pads_nxt = '0;
    for (int i = 0; i < 5; i++) begin
      case (cfg_r[i].src)
        2'h0: oval[i] = cfg_r[i].level;
        // Pins 2 and 4 have no forwarding path and keep the level bit.
        2'h1: oval[i] = (i == 2 || i == 4) ? cfg_r[i].level
                                           : filt_r[cfg_r[i].fwd];
        2'h2: oval[i] = seq_pin[i];
        default: oval[i] = ~supply_fault ^ cfg_r[i].level;
      endcase
      pads_nxt.oe_n[i] = 1'b1;
      if (run_ok) begin
        case (cfg_r[i].func)
          PGR_PP: begin
            pads_nxt.out[i] = oval[i];
            pads_nxt.oe_n[i] = 1'b0;
          end
          PGR_OD: begin
            pads_nxt.oe_n[i] = oval[i];
            pads_nxt.pull_up[i] = cfg_r[i].pull;
          end
          PGR_GPI: pads_nxt.pull_dn[i] = cfg_r[i].pull;
          default: pads_nxt.oe_n[i] = 1'b1;
        endcase
      end
    end
  end

  // Outside the working modes the pads float; configuration is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pads <= '{out: 5'h00, oe_n: 5'h1F, pull_up: 5'h00,
                           pull_dn: 5'h00};
    else pads <= pads_nxt;
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  always_comb begin
    rd_nxt = 32'h0000_0000;
    addr_ok = 1'b1;
    if (paddr <= `PGR_OFS_PIN4 && paddr[1:0] == 2'h0) begin
      rd_nxt[10:0] = cfg_r[pidx];
    end else if (paddr == `PGR_OFS_CTRL) begin
      rd_nxt[`PGR_CTRL_INOFF] = in_off_r;
      rd_nxt[`PGR_CTRL_ALTDEB] = alt_deb_r;
      rd_nxt[`PGR_CTRL_DEB_LSB+:16] = deb_len_r;
    end else if (paddr == `PGR_OFS_ONSRC) begin
      rd_nxt = on_src_r;
    end else if (paddr == `PGR_OFS_VSRC) begin
      rd_nxt = v_src_r;
    end else if (paddr == `PGR_OFS_ONBIT) begin
      rd_nxt[NREG-1:0] = reg_on;
    end else if (paddr == `PGR_OFS_VSEL) begin
      rd_nxt[NREG-1:0] = reg_vsel;
    end else if (paddr == `PGR_OFS_STAT) begin
      rd_nxt[13:0] = {wd_hold, supply_fault, run_request, platform_on,
                      act, filt_r};
    end else if (paddr == `PGR_OFS_EVT) begin
      rd_nxt[4:0] = evt_r;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Read data and error are captured in the setup cycle so the access
  // cycle can finish at once with registered data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r <= !addr_ok;
    end
  end
  assign prdata = prdata_r;
  assign pslverr = pslverr_r && psel && penable;
  assign pready = psel && penable;

  // Configuration writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 5; i++) cfg_r[i] <= '0;
      in_off_r <= 1'b0;
      alt_deb_r <= 1'b0;
      deb_len_r <= `PGR_DEB_RST;
      on_src_r <= 32'h0000_0000;
      v_src_r <= 32'h0000_0000;
    end else if (wr && !pslverr_r) begin
      if (paddr <= `PGR_OFS_PIN4) begin
        cfg_r[pidx] <= pgr_pin_cfg_t'(pwdata[`PGR_CFG_W-1:0]);
      end else if (paddr == `PGR_OFS_CTRL) begin
        in_off_r <= pwdata[`PGR_CTRL_INOFF];
        alt_deb_r <= pwdata[`PGR_CTRL_ALTDEB];
        deb_len_r <= pwdata[`PGR_CTRL_DEB_LSB+:16];
      end else if (paddr == `PGR_OFS_ONSRC) begin
        on_src_r <= pwdata;
      end else if (paddr == `PGR_OFS_VSRC) begin
        v_src_r <= pwdata;
      end
    end
  end

  // Event flags: write one to clear, a new event in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) evt_r <= 5'h00;
    else if (wr && paddr == `PGR_OFS_EVT) evt_r <= (evt_r & ~pwdata[4:0])
                                                   | evt_set;
    else evt_r <= evt_r | evt_set;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_off_highz: assert property (@(posedge pclk) disable iff (!presetn)
    !run_ok |=> pads.oe_n == 5'h1F) else $error("pads driven off");
  a_pp_level: assert property (@(posedge pclk) disable iff (!presetn)
    run_ok && cfg_r[1].func == PGR_PP && cfg_r[1].src == 2'h0
    |=> !pads.oe_n[1] && pads.out[1] == $past(cfg_r[1].level))
    else $error("push-pull level wrong");
  a_pull_down: assert property (@(posedge pclk) disable iff (!presetn)
    run_ok && gpi[1] && cfg_r[1].pull |=> pads.pull_dn[1])
    else $error("pull-down missing");
  a_event_edge: assert property (@(posedge pclk) disable iff (!presetn)
    gpi[1] && rise[1] |=> evt_r[1]) else $error("event lost");
  a_wake_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_r[1].wen && !cfg_r[3].wen && gpi[1] && gpi[3] && !alt[2]
    && !alt[4] && !gpi[0] && !gpi[2] && !gpi[4] |=> !wakeup)
    else $error("wakeup without enable");
  a_reg_on_set: assert property (@(posedge pclk) disable iff (!presetn)
    on_src_r[1:0] == 2'h1 && g_rise[1] |=> reg_on[0])
    else $error("regulator not enabled");
  a_fault_low: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(supply_fault) |-> $past(vlow_r) && $past(fcnt_r)
    == 32'(FAULT_CYCLES)) else $error("fault too early");
  a_wd_kick: assert property (@(posedge pclk) disable iff (!presetn)
    alt[0] && rise[0] |=> wd_service ##1 !wd_service)
    else $error("service pulse wrong");
  a_deb_hold: assert property (@(posedge pclk) disable iff (!presetn)
    deb_en[1] && in_ok && in_r[1] != filt_r[1] && cnt_r[1] == 16'h0000
    && deb_len_r > 16'h0002 |=> filt_r[1] == $past(filt_r[1]))
    else $error("debounce passed early");
endmodule
`default_nettype wire

// ### verification/pgr_pins.sv
// Model of the circuits outside the five pins: switches and pad loads.
// Assumes the pad bundle of the pin unit and a bench choosing drivers.
`timescale 1ns/1ps
`default_nettype none
module pgr_pins (
  input wire logic pclk,
  input wire pgr_pkg::pgr_pads_t pads,
  input wire logic [4:0] ext_drv,
  input wire logic [4:0] ext_en,
  output logic [4:0] pad_in
);
  import pgr_pkg::*;
  logic [4:0] last_r;

  // Pad level: unit driver first, then a switch, then the pulls.
  // A pad nobody holds flips each cycle so a stale value never passes.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!pads.oe_n[i]) begin
        pad_in[i] = pads.out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_drv[i];
      end else if (pads.pull_up[i]) begin
        pad_in[i] = 1'b1;
      end else if (pads.pull_dn[i]) begin
        pad_in[i] = 1'b0;
      end else begin
        pad_in[i] = ~last_r[i];
      end
    end
  end

  // Remember the last level so a floating pad can be made to wander.
  always_ff @(posedge pclk) begin
    last_r <= pad_in;
  end
endmodule
`default_nettype wire

// ### verification/pgr_gpio_tb.sv
// Self-checking bench for the pin unit: APB traffic and pin stimulus.
// Assumes the pad model pgr_pins and the offsets of pgr_map.svh.
`timescale 1ns/1ps
`default_nettype none
`include "pgr_map.svh"
module pgr_gpio_tb;
  import pgr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] pad_in, ext_drv, ext_en;
  pgr_pads_t pads;
  logic mode_active, mode_powerdown, vsys_low;
  logic [4:0] seq_pin;
  logic [3:0] seq_on_we, seq_on_val;
  logic [3:0] reg_on, reg_vsel;
  logic seq_wait_edge, wakeup, platform_on, run_request, powerdown_req;
  logic wd_service, wd_hold, supply_fault;
  int fails, total_checks, n_wake, n_wds, n_seq, w0;

  pgr_gpio #(.NREG(4), .FAULT_CYCLES(20)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pads(pads),
    .mode_active(mode_active), .mode_powerdown(mode_powerdown),
    .vsys_low(vsys_low), .seq_pin(seq_pin), .seq_on_we(seq_on_we),
    .seq_on_val(seq_on_val), .seq_vsel_we(4'h0), .seq_vsel_val(4'h0),
    .reg_on(reg_on), .reg_vsel(reg_vsel), .seq_wait_edge(seq_wait_edge),
    .wakeup(wakeup), .platform_on(platform_on), .run_request(run_request),
    .powerdown_req(powerdown_req), .wd_service(wd_service),
    .wd_hold(wd_hold), .supply_fault(supply_fault));

  pgr_pins pins_u (.pclk(pclk), .pads(pads), .ext_drv(ext_drv),
    .ext_en(ext_en), .pad_in(pad_in));

  // 200 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Count one-cycle pulses so a scenario can compare how many came.
  always @(posedge pclk) begin
    if (wakeup === 1'b1) n_wake++;
    if (wd_service === 1'b1) n_wds++;
    if (seq_wait_edge === 1'b1) n_seq++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; idles a cycle after so psel never changes twice.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic pin(input int i, input logic en, input logic v);
    ext_en[i] <= en;
    ext_drv[i] <= v;
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] fn, input logic lv,
      input logic pol, input logic wen, input logic pull,
      input logic [1:0] src);
    return {23'h0, src, pull, wen, 1'b0, pol, lv, fn};
  endfunction

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cut a hang short; the tests need well under 1500 cycles.
  initial begin
    #15000;
    fails++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, vsys_low, mode_powerdown} = 6'h00;
    mode_active = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_drv = 5'h00;
    ext_en = 5'h00;
    seq_pin = 5'h00;
    seq_on_we = 4'h0;
    seq_on_val = 4'h0;
    tick(4);
    presetn <= 1'b1;
    tick(1);
    apb(1'b0, `PGR_OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0010_0000, rd);
    chk("oe reset", 32'h1F, {27'h0, pads.oe_n});
    apb(1'b1, 8'h30, 32'hFFFF_FFFF);
    chk("unmapped", 32'h1, {31'h0, err});
    // Pin 1 drives two regulators; the pull-down keeps it passive.
    apb(1'b1, `PGR_OFS_PIN0 + 8'h04, cfg(PGR_GPI, 0, 1, 1, 1, 0));
    apb(1'b1, `PGR_OFS_ONSRC, 32'h0000_0011);
    tick(10);
    chk("pull down", 32'h1, {31'h0, pads.pull_dn[1]});
    chk("on idle", 32'h0, {28'h0, reg_on});
    w0 = n_wake;
    pin(1, 1, 1);
    tick(10);
    chk("on set", 32'h5, {28'h0, reg_on});
    chk("wakeup", 32'h1, n_wake - w0);
    apb(1'b0, `PGR_OFS_STAT, 32'h0);
    chk("active", 32'h1, {31'h0, rd[6]});
    apb(1'b0, `PGR_OFS_EVT, 32'h0);
    chk("event", 32'h2, rd & 32'h1F);
    apb(1'b1, `PGR_OFS_EVT, 32'h2);
    apb(1'b0, `PGR_OFS_EVT, 32'h0);
    chk("event clear", 32'h0, rd & 32'h1F);
    pin(1, 1, 0);
    tick(10);
    chk("on clear", 32'h0, {28'h0, reg_on});
    // Sequencer only reaches regulators 1 and 3; pin 1 owns 0 and 2.
    seq_on_we <= 4'hF;
    seq_on_val <= 4'hF;
    tick(1);
    seq_on_we <= 4'h0;
    tick(2);
    chk("seq ignored", 32'hA, {28'h0, reg_on});
    apb(1'b1, `PGR_OFS_ONBIT, 32'h1);
    tick(1);
    chk("on write", 32'h1, {28'h0, reg_on});
    apb(1'b1, `PGR_OFS_ONBIT, 32'h0);
    // Pin 2 active low, debounced over 8 cycles, selects voltage.
    apb(1'b1, `PGR_OFS_CTRL, 32'h0008_0000);
    pin(2, 1, 1);
    apb(1'b1, `PGR_OFS_PIN0 + 8'h08, cfg(PGR_GPI, 1, 0, 0, 0, 0));
    apb(1'b1, `PGR_OFS_VSRC, 32'h0000_0008);
    tick(20);
    pin(2, 1, 0);
    tick(4);
    pin(2, 1, 1);
    tick(16);
    chk("glitch", 32'h0, {28'h0, reg_vsel});
    pin(2, 1, 0);
    tick(20);
    chk("vsel set", 32'h2, {28'h0, reg_vsel});
    // Pin 3 feeds the sequencer and is forwarded to output 0.
    pin(3, 1, 0);
    apb(1'b1, `PGR_OFS_PIN0 + 8'h0C, cfg(PGR_GPI, 0, 1, 0, 0, 0));
    apb(1'b1, `PGR_OFS_PIN0, cfg(PGR_PP, 0, 0, 0, 0, 1) | 32'h600);
    tick(10);
    w0 = n_seq;
    pin(3, 1, 1);
    tick(10);
    chk("fwd high", 32'h1, {31'h0, pads.out[0]});
    pin(3, 1, 0);
    tick(10);
    chk("fwd low", 32'h0, {30'h0, pads.oe_n[0], pads.out[0]});
    chk("seq edge", 32'h1, n_seq - w0);
    // Open-drain low with pull-up, and supply fault on pin 1.
    pin(1, 0, 0);
    apb(1'b1, `PGR_OFS_PIN0 + 8'h10, cfg(PGR_OD, 0, 0, 0, 1, 0));
    apb(1'b1, `PGR_OFS_PIN0 + 8'h04, cfg(PGR_PP, 0, 0, 0, 0, 3));
    tick(2);
    chk("od low", 32'h1, {pads.out[4], pads.oe_n[4], pads.pull_up[4]});
    chk("fault idle", 32'h1, {31'h0, pads.out[1]});
    vsys_low <= 1'b1;
    tick(10);
    chk("fault early", 32'h0, {31'h0, supply_fault});
    tick(30);
    chk("fault", 32'h2, {30'h0, supply_fault, pads.out[1]});
    mode_active <= 1'b0;
    tick(3);
    chk("mode off", 32'h1F, {27'h0, pads.oe_n});
    mode_active <= 1'b1;
    tick(3);
    chk("retained", 32'h0, {31'h0, pads.oe_n[4]});
    seq_pin <= 5'h02;
    apb(1'b1, `PGR_OFS_PIN0 + 8'h04, cfg(PGR_PP, 0, 0, 0, 0, 2));
    tick(2);
    chk("seq out", 32'h1, {31'h0, pads.out[1]});
    // Watchdog service pin, active high, then held asserted.
    pin(0, 1, 0);
    apb(1'b1, `PGR_OFS_PIN0, cfg(PGR_ALT, 0, 1, 0, 0, 0));
    tick(10);
    w0 = n_wds;
    pin(0, 1, 1);
    tick(12);
    chk("wd service", 32'h3, {n_wds[0] ^ w0[0], wd_hold});
    stop_test();
  end
endmodule
`default_nettype wire
